// [rtl/ladder_condition_evaluator.sv]
// Operation
// - a load-type instruction starts a fresh condition, ignoring the previous one
// - normally open uses the bit as is, normally closed its inverse
// - inverted load gives ON exactly when the operand bit is OFF
// - series combine ANDs the condition with the operand bit
// - inverted series combine ANDs the condition with the complemented bit
// - parallel combine ORs the condition with the bit, inverted form the complement
// - all but load-type instructions are governed by the prior condition; here end acts regardless of the condition
// - I/O, work, data-area and dedicated bits are all valid contact operands
// - program memory starts at address zero and holds 144 words
// - one instruction with its operands takes one to five words
// - first word holds opcode, definers and a lone bit operand; rest operands
// - constant-prefixed operands are literals, others are word addresses
// - the program is stored as machine-code instruction words
// - execute up to first end instruction, then restart from address zero
// - drive sets its bit to the condition, inverted drive to its complement
`timescale 1ns/1ps
`default_nettype none
module ladder_condition_evaluator
  import ladder_pkg::*;
(
  input  wire logic              sys_clk,    // 10 MHz clock
  input  wire logic              arst_n,     // async reset, low active
  input  wire logic              run,        // high: execute program
  input  wire logic              prog_we,    // program word write strobe
  input  wire logic [PC_W-1:0]   prog_addr,  // program word address
  input  wire logic [WORD_W-1:0] prog_wdata, // program word
  input  wire logic [WORD_W-1:0] io_in,      // input terminals
  output logic      [WORD_W-1:0] io_out,     // output terminals
  output logic                   cond_out,   // execution condition
  output logic                   scan_done,  // pulse at end instruction
  output logic                   fault       // ran off memory without end
);

  // ************************************************************
  // storage
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HALT} state_t;

  logic [WORD_W-1:0] pmem [0:PMEM_WORDS-1];
  logic [WORD_W-1:0] dmem [0:DMEM_WORDS-1];

  state_t            state_reg;
  state_t            state_next;
  logic [PC_W-1:0]   pc_reg;
  logic [PC_W-1:0]   pc_next;
  logic              cond_reg;
  logic              cond_next;
  logic [WORD_W-1:0] io_out_reg;
  logic              scan_done_reg;
  logic              fault_reg;

  // ************************************************************
  // fetch and decode
  // ************************************************************
  wire              pc_valid  = pc_reg < PC_W'(PMEM_WORDS);
  wire [PC_W-1:0]   pc_p1     = pc_reg + LEN_ONE;
  wire [PC_W-1:0]   pc_p2     = pc_reg + 8'h02;
  wire [WORD_W-1:0] instr_w   = pc_valid ? pmem[pc_reg] : {WORD_W{1'b0}};
  wire [WORD_W-1:0] opd1_w    = (pc_p1 < PC_W'(PMEM_WORDS)) ? pmem[pc_p1] : {WORD_W{1'b0}};
  wire [WORD_W-1:0] opd2_w    = (pc_p2 < PC_W'(PMEM_WORDS)) ? pmem[pc_p2] : {WORD_W{1'b0}};
  wire [3:0]        opc       = instr_w[OPC_LSB +: 4];
  wire [5:0]        bit_word  = instr_w[WSEL_LSB +: 6];
  wire [3:0]        bit_sel   = instr_w[BSEL_LSB +: 4];
  wire              opd_bit   = dmem[bit_word][bit_sel];
  wire              exec      = (state_reg == ST_RUN) && pc_valid;

  wire              is_load   = (opc == OPC_LOAD) || (opc == OPC_LOAD_INV);
  wire              is_and    = (opc == OPC_AND) || (opc == OPC_AND_INV);
  wire              is_or     = (opc == OPC_OR) || (opc == OPC_OR_INV);
  wire              is_drive  = (opc == OPC_DRIVE) || (opc == OPC_DRIVE_INV);
  wire              is_copy   = opc == OPC_WORD_COPY;
  wire              is_end    = opc == OPC_END;
  wire              inv       = (opc == OPC_LOAD_INV) || (opc == OPC_AND_INV) || (opc == OPC_OR_INV);
  wire              contact   = opd_bit ^ inv;

  // instruction length 1..5 words
  wire [PC_W-1:0]   xlen      = {5'h00, instr_w[XLEN_LSB +: 3]};
  wire [PC_W-1:0]   ilen      = is_copy ? LEN_COPY :
                                (opc == OPC_RIGHT_HAND) ? ((xlen > 8'h04) ? 8'h05 : xlen + LEN_ONE) :
                                LEN_ONE;

  // word_copy source: literal or addressed word
  wire [WORD_W-1:0] copy_src  = opd1_w[CONST_BIT] ? {1'b0, opd1_w[WORD_W-2:0]}
                                                  : dmem[opd1_w[5:0]];
  wire [5:0]        copy_dst  = opd2_w[5:0];
  wire              do_copy   = exec && is_copy && cond_reg;
  wire              do_drive  = exec && is_drive;
  wire              drive_val = cond_reg ^ (opc == OPC_DRIVE_INV);

  // ************************************************************
  // sequencing
  // ************************************************************
  assign cond_next = !exec   ? cond_reg :
                     is_load ? contact :
                     is_and  ? (cond_reg & contact) :
                     is_or   ? (cond_reg | contact) :
                     cond_reg;

  assign pc_next = (state_reg != ST_RUN) ? PC_START :
                   !pc_valid             ? pc_reg :
                   is_end                ? PC_START :
                   pc_reg + ilen;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (run) state_next = ST_RUN;
      ST_RUN: begin
        if (!pc_valid) state_next = ST_HALT;
        else if (is_end && !run) state_next = ST_IDLE;
      end
      ST_HALT: if (!run) state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= ST_IDLE;
      pc_reg        <= PC_START;
      cond_reg      <= 1'b0;
      io_out_reg    <= 16'h0000;
      scan_done_reg <= 1'b0;
      fault_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      pc_reg        <= pc_next;
      cond_reg      <= cond_next;
      io_out_reg    <= dmem[IO_OUT_WORD];
      scan_done_reg <= exec && is_end;
      fault_reg     <= (state_next == ST_HALT);
    end
  end

  // ************************************************************
  // memories: program load, bit areas
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (prog_we && (prog_addr < PC_W'(PMEM_WORDS))) begin
      pmem[prog_addr] <= prog_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (do_drive) begin
      dmem[bit_word][bit_sel] <= drive_val;
    end
    if (do_copy) begin
      dmem[copy_dst] <= copy_src;
    end
    dmem[IO_IN_WORD] <= io_in;
  end

  assign io_out    = io_out_reg;
  assign cond_out  = cond_reg;
  assign scan_done = scan_done_reg;
  assign fault     = fault_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_contact(logic [3:0] code);
    exec && (opc == code);
  endsequence

  sequence s_end_hit;
    exec && is_end;
  endsequence

  a_load_plain_bit: assert property (s_contact(OPC_LOAD) |=> cond_reg == $past(opd_bit))
    else $error("load did not copy operand bit");
  a_load_inv_bit: assert property (s_contact(OPC_LOAD_INV) |=> cond_reg != $past(opd_bit))
    else $error("inverted load not complement of bit");
  a_load_fresh_start: assert property (exec && is_load && !contact |=> !cond_reg)
    else $error("load kept prior condition");
  a_series_and: assert property (s_contact(OPC_AND) |=> cond_reg == ($past(cond_reg) & $past(opd_bit)))
    else $error("series combine wrong");
  a_series_and_inv: assert property (s_contact(OPC_AND_INV) |=>
                                     cond_reg == ($past(cond_reg) & !$past(opd_bit)))
    else $error("inverted series combine wrong");
  a_parallel_or: assert property (exec && is_or |=>
                                  cond_reg == ($past(cond_reg) | ($past(opd_bit) ^ $past(opc == OPC_OR_INV))))
    else $error("parallel combine wrong");
  a_cond_holds: assert property (exec && !is_load && !is_and && !is_or |=> $stable(cond_reg))
    else $error("condition changed without contact");
  a_drive_follows: assert property (do_drive && (bit_word != IO_IN_WORD) |=>
                                    dmem[$past(bit_word)][$past(bit_sel)] == ($past(cond_reg) ^ $past(opc == OPC_DRIVE_INV)))
    else $error("drive bit not set from condition");
  a_copy_gated: assert property (exec && is_copy && !cond_reg && (copy_dst != IO_IN_WORD) |=>
                                 dmem[$past(copy_dst)] == $past(dmem[copy_dst]))
    else $error("copy executed with condition off");
  a_end_restart: assert property (s_end_hit ##0 run |=> (pc_reg == PC_START) ##0 scan_done)
    else $error("no restart after end");
  a_overrun_fault: assert property ((state_reg == ST_RUN) && !pc_valid |=>
                                    fault && (state_reg == ST_HALT))
    else $error("no fault after running off memory");

  // ************************************************************
  // checks: sequencing and operands
  // ************************************************************
  sequence s_one_word_step;
    exec && (is_load || is_and || is_or || is_drive);
  endsequence

  sequence s_copy_step;
    exec && is_copy;
  endsequence

  a_fault_held: assert property (fault && run |=> fault)
    else $error("fault dropped while run high");
  a_step_single: assert property (s_one_word_step |=> pc_reg == $past(pc_reg) + 8'h01)
    else $error("one-word instruction mis-stepped");
  a_step_copy: assert property (s_copy_step |=> pc_reg == $past(pc_reg) + 8'h03)
    else $error("copy instruction mis-stepped");
  a_run_low_ignored: assert property (exec && !is_end && !run |=> state_reg == ST_RUN)
    else $error("run low honoured before end");
  a_end_to_idle: assert property (s_end_hit ##0 !run |=> (state_reg == ST_IDLE) && scan_done)
    else $error("no stop at end with run low");
  a_copy_literal: assert property (s_copy_step ##0 (cond_reg && opd1_w[CONST_BIT]) ##0
                                   (copy_dst != IO_IN_WORD) |=>
                                   dmem[$past(copy_dst)] == {1'b0, $past(opd1_w[WORD_W-2:0])})
    else $error("literal copy value wrong");

endmodule
`default_nettype wire

// [common/ladder_pkg.sv]
`default_nettype none
package ladder_pkg;

  // ************************************************************
  // program memory
  // ************************************************************
  localparam int          PMEM_WORDS = 144;
  localparam int          WORD_W     = 16;
  localparam int          PC_W       = 8;
  localparam logic [7:0]  PC_START   = 8'h00;

  // ************************************************************
  // first word: [15:12] opcode, [9:8] area, [9:4] word, [3:0] bit
  // ************************************************************
  localparam int OPC_LSB  = 12;
  localparam int AREA_LSB = 8;
  localparam int WSEL_LSB = 4;
  localparam int BSEL_LSB = 0;
  localparam int XLEN_LSB = 0;   // extra words of a plain right-hand instruction

  localparam logic [3:0] OPC_END        = 4'h0;
  localparam logic [3:0] OPC_LOAD       = 4'h1;  // load_condition
  localparam logic [3:0] OPC_LOAD_INV   = 4'h2;  // load_inverted
  localparam logic [3:0] OPC_AND        = 4'h3;
  localparam logic [3:0] OPC_AND_INV    = 4'h4;
  localparam logic [3:0] OPC_OR         = 4'h5;
  localparam logic [3:0] OPC_OR_INV     = 4'h6;
  localparam logic [3:0] OPC_DRIVE      = 4'h7;
  localparam logic [3:0] OPC_DRIVE_INV  = 4'h8;
  localparam logic [3:0] OPC_WORD_COPY  = 4'h9;  // word_copy: source word, destination word
  localparam logic [3:0] OPC_RIGHT_HAND = 4'hA;  // other right-hand, 1..5 words, no effect

  localparam logic [7:0] LEN_ONE  = 8'h01;
  localparam logic [7:0] LEN_COPY = 8'h03;

  // ************************************************************
  // operand words: [15] constant prefix, [5:0] word index
  // ************************************************************
  localparam int CONST_BIT = 15;

  // ************************************************************
  // bit areas, 16 words each
  // ************************************************************
  localparam int         DMEM_WORDS  = 64;
  localparam logic [1:0] AREA_IO     = 2'h0;
  localparam logic [1:0] AREA_WORK   = 2'h1;
  localparam logic [1:0] AREA_DATA   = 2'h2;  // data_area_bit
  localparam logic [1:0] AREA_FLAG   = 2'h3;
  localparam logic [5:0] IO_IN_WORD  = 6'h00;
  localparam logic [5:0] IO_OUT_WORD = 6'h01;

endpackage
`default_nettype wire

// [test/tb_ladder_condition_evaluator.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_ladder_condition_evaluator;
  import ladder_pkg::*;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

  logic              sys_clk;
  logic              arst_n;
  logic              run;
  logic              prog_we;
  logic [PC_W-1:0]   prog_addr;
  logic [WORD_W-1:0] prog_wdata;
  logic [WORD_W-1:0] io_in;
  logic [WORD_W-1:0] io_out;
  logic              cond_out;
  logic              scan_done;
  logic              fault;
  int                seed = 32'h527af538;
  int                err_count;
  int                cmp_count;
  int                cyc;
  logic [15:0]       pg [$];
  logic [15:0]       mm [64];

  ladder_condition_evaluator dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .run(run), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .io_in(io_in), .io_out(io_out), .cond_out(cond_out),
    .scan_done(scan_done), .fault(fault));

  always #50 sys_clk = ~sys_clk;

  // ************
  // helpers
  // ************
  function automatic logic [3:0] r4();
    return 4'($random(seed));
  endfunction

  function automatic logic [15:0] ins(logic [3:0] op, logic [5:0] idx, logic [3:0] b);
    return {op, 2'b00, idx, b};
  endfunction

  // one scan of the program, returns the final condition
  function automatic logic model_scan();
    logic c;
    logic v;
    logic [15:0] w;
    int pc;
    c = 1'b0;
    pc = 0;
    mm[0] = io_in;
    while (pc < pg.size()) begin
      w = pg[pc];
      v = mm[w[9:4]][w[3:0]];
      if (w[15:12] == OPC_END) break;
      case (w[15:12])
        OPC_LOAD:      c = v;
        OPC_LOAD_INV:  c = ~v;
        OPC_AND:       c = c & v;
        OPC_AND_INV:   c = c & ~v;
        OPC_OR:        c = c | v;
        OPC_OR_INV:    c = c | ~v;
        OPC_DRIVE:     mm[w[9:4]][w[3:0]] = c;
        OPC_DRIVE_INV: mm[w[9:4]][w[3:0]] = ~c;
        OPC_WORD_COPY: begin
          if (c) mm[pg[pc+2][5:0]] = pg[pc+1][CONST_BIT] ? {1'b0, pg[pc+1][14:0]} : mm[pg[pc+1][5:0]];
          pc += 2;
        end
        OPC_RIGHT_HAND: pc += (w[2:0] > 3'h4) ? 4 : w[2:0];
        default: ;
      endcase
      pc++;
    end
    return c;
  endfunction

  task automatic gen_contacts();
    logic [9:0] pool [4];
    logic [5:0] idx;
    int n;
    int k;
    int p;
    logic [3:0] x;
    for (k = 1; k < 4; k++) begin
      idx = {k[1:0], r4()};
      pool[k] = {idx, r4()};
      pg.push_back(ins(OPC_LOAD, 6'h00, r4()));
      pg.push_back(ins(OPC_DRIVE, idx, pool[k][3:0]));
    end
    n = 2 + ($unsigned($random(seed)) % 7);
    for (k = 0; k < n; k++) begin
      pool[0] = {6'h00, r4()};
      p = $unsigned($random(seed)) % 4;
      pg.push_back(ins(4'((k == 0) ? 1 + $unsigned($random(seed)) % 2 : 1 + $unsigned($random(seed)) % 6),
                       pool[p][9:4], pool[p][3:0]));
    end
    x = r4();
    pg.push_back(ins(OPC_RIGHT_HAND, 6'h00, x));
    repeat ((x[2:0] > 3'h4) ? 4 : x[2:0]) pg.push_back(ins(OPC_END, 6'h00, 4'h0));
    pg.push_back(ins(OPC_DRIVE, IO_OUT_WORD, 4'h0));
    pg.push_back(ins(OPC_DRIVE_INV, IO_OUT_WORD, 4'h1));
  endtask

  task automatic run_prog(input logic ends);
    int i;
    logic e;
    repeat (40) @(negedge sys_clk);
    for (i = 0; i < pg.size(); i++) begin
      prog_we = 1'b1;
      prog_addr = i[7:0];
      prog_wdata = pg[i];
      @(negedge sys_clk);
    end
    prog_we = 1'b0;
    io_in = 16'($random(seed));
    e = model_scan();
    run = 1'b1;
    i = 0;
    while (scan_done !== 1'b1 && fault !== 1'b1 && i < 300) begin
      @(negedge sys_clk);
      i++;
    end
    `CHK(scan_done, ends)
    `CHK(cond_out, e)
    `CHK(io_out, mm[1])
    `CHK(fault, !ends)
    run = 1'b0;
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  // ************
  // main sequence
  // ************
  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    run = 1'b0;
    prog_we = 1'b0;
    prog_addr = 8'h00;
    prog_wdata = 16'h0000;
    io_in = 16'h0000;
    repeat (3) @(negedge sys_clk);
    `CHK({io_out, cond_out, scan_done, fault}, 19'h00000)
    arst_n = 1'b1;
    pg = '{ins(OPC_LOAD, 6'h00, 4'h0), ins(OPC_OR_INV, 6'h00, 4'h0), ins(OPC_WORD_COPY, 6'h00, 4'h0),
           16'h8000, {10'h000, IO_OUT_WORD}, ins(OPC_END, 6'h00, 4'h0)};
    run_prog(1'b1);
    $display("output word clear test done");
    for (int t = 0; t < 32; t++) begin
      pg.delete();
      if (t % 4 < 2) begin
        gen_contacts();
      end else begin
        pg.push_back(ins(OPC_LOAD, 6'h00, 4'h0));
        pg.push_back(ins(OPC_WORD_COPY, 6'h00, 4'h0));
        pg.push_back((t % 4 == 2) ? (16'h8000 | 16'($random(seed))) : 16'h0000);
        pg.push_back({10'h000, IO_OUT_WORD});
      end
      pg.push_back(ins(OPC_END, 6'h00, 4'h0));
      run_prog(1'b1);
      $display("test %0d done", t);
    end
    pg.delete();
    repeat (PMEM_WORDS) pg.push_back(ins(OPC_LOAD_INV, 6'h00, 4'h0));
    run_prog(1'b0);
    $display("overrun test done");
    test_done();
  end
endmodule
`default_nettype wire
